// ---- pkg/dma7_pkg.sv ----
// Package: constants, types and descriptor layout of the level-7 engine
// Summary of operation
// - Only level-7 interrupt requests start a transfer
// - Needs engine select set, fast select clear
// - Mode bit 0 picks 8 or 16 bit unit
// - All data addresses are 16 bits wide
// - 16-bit access at top reaches next byte
// - Incrementing address steps by unit, fixed stays
// - Separate fixed/increment bits for source, destination
// - Source word is immediate data or address
// - Add mode sums source and operand data
// - Single moves one item, burst moves all
// - Zero count raises completion interrupt with handler
// - Chain rewrites requester vector with next descriptor
// - Bit 15 turns bits 6-4 into repeat count
// - Descriptor is 8-32 bytes in fixed order
// - Word fields two bytes, chain/handler four bytes
// - Optional fields exist only when their mode used
// - Repeat mode holds up to seven address pairs
// - Descriptor base is read from requester vector
// - Zero counter moves no data
// - Counter drops per item; burst ends at zero
// - 8-bit immediate uses only the low byte
// - No interrupt acknowledge during burst or repeats
package dma7_pkg;
  localparam logic [2:0] LVL_TOP     = 3'h7;
  localparam int         BIT_SIZE    = 0;
  localparam int         BIT_SRC_MEM  = 1;
  localparam int         BIT_SRC_INC  = 2;
  localparam int         BIT_DST_INC  = 3;
  localparam int         BIT_ADD      = 4;
  localparam int         BIT_BURST    = 5;
  localparam int         BIT_DONE_IRQ = 6;
  localparam int         BIT_CHAIN    = 7;
  localparam int         BIT_PAIRS    = 15;
  localparam logic [5:0] OFS_CNT     = 6'h02;
  localparam logic [5:0] OFS_FLD     = 6'h04;
  localparam logic [5:0] LEN_VEC     = 6'h04;
  localparam logic [5:0] LEN_HDR     = 6'h04;
  localparam logic [5:0] LEN_WORD    = 6'h02;
  localparam logic [5:0] LEN_LONG    = 6'h04;
  localparam int         DESC_MAX    = 32;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

  // One byte access on the shared memory bus
  typedef struct packed {
    logic        we;
    logic [31:0] addr;
    logic [7:0]  data;
  } mem_cmd_t;

  typedef enum logic [3:0] {
    S_IDLE, S_VEC, S_HDR, S_FLD, S_SRC, S_OPR, S_DST, S_WB, S_CHAIN
  } eng_state_t;
endpackage : dma7_pkg

// ---- rtl/level7_dma_engine.sv ----
// Descriptor-driven transfer engine started by level-7 requests
`timescale 1ns/1ps
module level7_dma_engine #(
  parameter int BUF_DEPTH = 2
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_arst_n,
  input  wire logic              i_req_valid,
  input  wire logic [2:0]        i_req_level,
  input  wire logic [31:0]       i_req_vector_addr,
  input  wire logic              i_level7_engine_select,
  input  wire logic              i_fast_interrupt_select,
  output logic                   o_req_ack,
  output logic                   o_mem_valid,
  input  wire logic              i_mem_ready,
  output dma7_pkg::mem_cmd_t     o_mem_cmd,
  input  wire logic              i_mem_rvalid,
  input  wire logic [7:0]        i_mem_rdata,
  output logic                   o_irq_hold,
  output logic                   o_eot_irq,
  output logic [31:0]            o_eot_handler_addr,
  output logic                   o_busy
);
  if (BUF_DEPTH < 2) begin : g_bad_depth
    $error("level7_dma_engine needs BUF_DEPTH of at least 2");
  end

  dma7_pkg::eng_state_t st_reg, st_next;
  logic [7:0]  desc_reg [dma7_pkg::DESC_MAX];
  logic [7:0]  desc_next [dma7_pkg::DESC_MAX];
  logic [5:0]  idx_reg, idx_next;
  logic        pend_reg, pend_next;
  logic [31:0] vec_reg, vec_next, base_reg, base_next;
  logic [15:0] acc_reg, acc_next, dat_reg, dat_next;
  logic [2:0]  pair_reg, pair_next;
  logic        eot_reg, eot_next;
  logic [31:0] hand_reg, hand_next;

  logic [15:0] mode, cnt, src, opr, dst, unit, s_new, o_new, d_new, c_dec;
  logic        pairs_on, add, burst_on, done_irq_on, chain;
  logic        src_mem, take, issue;
  logic        buf_ready, step_done, more;
  logic [2:0]  rep;
  logic [5:0]  o_src, o_opr, o_dst, o_cad, o_iad, flen, len;
  logic [31:0] baddr;
  dma7_pkg::eng_state_t first_st;
  dma7_pkg::mem_cmd_t   cmd;

  function automatic logic [15:0] fit(input logic [15:0] v,
                                      input logic s16);
    fit = s16 ? v : {8'h00, v[7:0]};
  endfunction : fit

  // Mode decode; bits 6-4 change meaning in repeat mode
  assign mode  = {desc_reg[1], desc_reg[0]};
  assign cnt   = {desc_reg[3], desc_reg[2]};
  assign pairs_on = mode[dma7_pkg::BIT_PAIRS];
  assign rep   = mode[6:4];
  assign add   = !pairs_on && mode[dma7_pkg::BIT_ADD];
  assign burst_on = !pairs_on && mode[dma7_pkg::BIT_BURST];
  assign done_irq_on = !pairs_on && mode[dma7_pkg::BIT_DONE_IRQ];
  assign chain = !pairs_on && mode[dma7_pkg::BIT_CHAIN];
  assign unit  = mode[dma7_pkg::BIT_SIZE] ? 16'h0002 : 16'h0001;
  assign src_mem = pairs_on || mode[dma7_pkg::BIT_SRC_MEM];

  // Field offsets; optional fields only take room when used
  assign o_src = pairs_on ? dma7_pkg::OFS_FLD + {1'b0, pair_reg, 2'b00}
                          : dma7_pkg::OFS_FLD;
  assign o_opr = o_src + dma7_pkg::LEN_WORD;
  assign o_dst = o_opr + (add ? dma7_pkg::LEN_WORD : 6'h00);
  assign o_cad = o_dst + dma7_pkg::LEN_WORD;
  assign o_iad = o_cad + (chain ? dma7_pkg::LEN_LONG : 6'h00);
  assign flen  = pairs_on ? dma7_pkg::OFS_FLD + {1'b0, rep, 2'b00}
                 : o_iad + (done_irq_on ? dma7_pkg::LEN_LONG : 6'h00);
  assign src   = {desc_reg[o_src[4:0] + 5'h01], desc_reg[o_src[4:0]]};
  assign opr   = {desc_reg[o_opr[4:0] + 5'h01], desc_reg[o_opr[4:0]]};
  assign dst   = {desc_reg[o_dst[4:0] + 5'h01], desc_reg[o_dst[4:0]]};

  // Address steps wrap inside the 16-bit space
  assign s_new = src +
                 (mode[dma7_pkg::BIT_SRC_INC] ? unit : 16'h0000);
  assign o_new = opr +
                 (mode[dma7_pkg::BIT_SRC_INC] ? unit : 16'h0000);
  assign d_new = dst +
                 (mode[dma7_pkg::BIT_DST_INC] ? unit : 16'h0000);
  assign c_dec = cnt - 16'h0001;
  assign more  = (c_dec != 16'h0000) &&
                 (burst_on ||
                  (pairs_on && (pair_reg + 3'h1) < rep));
  assign first_st = src_mem ? dma7_pkg::S_SRC
                  : (add ? dma7_pkg::S_OPR : dma7_pkg::S_DST);

  // Request filter: level 7 only, engine routed, fast path off
  assign take = (st_reg == dma7_pkg::S_IDLE) && i_req_valid &&
                (i_req_level == dma7_pkg::LVL_TOP) &&
                i_level7_engine_select &&
                !i_fast_interrupt_select;
  assign o_req_ack  = take;
  assign o_busy     = (st_reg != dma7_pkg::S_IDLE);
  // Mode bits are stale until the header is in, so hold only after it
  assign o_irq_hold = o_busy && (st_reg != dma7_pkg::S_VEC) &&
                      (st_reg != dma7_pkg::S_HDR) &&
                      (burst_on || pairs_on);
  assign o_eot_irq  = eot_reg;
  assign o_eot_handler_addr = hand_reg;

  // Byte count and base address of the current access run
  always_comb begin
    len   = 6'h00;
    baddr = vec_reg;
    case (st_reg)
      dma7_pkg::S_VEC:   len = dma7_pkg::LEN_VEC;
      dma7_pkg::S_HDR: begin
        len   = dma7_pkg::LEN_HDR;
        baddr = base_reg;
      end
      dma7_pkg::S_FLD: begin
        len   = flen;
        baddr = base_reg;
      end
      dma7_pkg::S_SRC: begin
        len   = unit[5:0];
        baddr = {16'h0000, src};
      end
      dma7_pkg::S_OPR: begin
        len   = unit[5:0];
        baddr = {16'h0000, opr};
      end
      dma7_pkg::S_DST: begin
        len   = unit[5:0];
        baddr = {16'h0000, dst};
      end
      dma7_pkg::S_WB: begin
        len   = pairs_on ? dma7_pkg::OFS_FLD : o_cad;
        baddr = base_reg;
      end
      dma7_pkg::S_CHAIN: len = dma7_pkg::LEN_LONG;
      default:           len = 6'h00;
    endcase
  end

  // Command for the byte at the current index
  always_comb begin
    cmd.addr = baddr + {26'h0000000, idx_reg};
    cmd.we   = (st_reg == dma7_pkg::S_DST) || (st_reg == dma7_pkg::S_WB) ||
               (st_reg == dma7_pkg::S_CHAIN);
    case (st_reg)
      dma7_pkg::S_DST:   cmd.data = idx_reg[0] ? dat_reg[15:8]
                                               : dat_reg[7:0];
      dma7_pkg::S_WB:    cmd.data = desc_reg[idx_reg[4:0]];
      dma7_pkg::S_CHAIN: cmd.data = desc_reg[o_cad[4:0] + idx_reg[4:0]];
      default:           cmd.data = 8'h00;
    endcase
  end

  assign issue = o_busy && !pend_reg && (idx_reg != len) && buf_ready;
  assign step_done = o_busy && !pend_reg && (idx_reg == len);

  // Sequencer: fetch vector, descriptor, move items, write back
  always_comb begin
    st_next   = st_reg;
    desc_next = desc_reg;
    idx_next  = idx_reg;
    pend_next = pend_reg;
    vec_next  = vec_reg;
    base_next = base_reg;
    acc_next  = acc_reg;
    dat_next  = dat_reg;
    pair_next = pair_reg;
    eot_next  = 1'b0;
    hand_next = hand_reg;
    if (issue) begin
      if (cmd.we) begin
        idx_next = idx_reg + 6'h01;
      end else begin
        pend_next = 1'b1;
      end
    end
    if (pend_reg && i_mem_rvalid) begin
      pend_next = 1'b0;
      idx_next  = idx_reg + 6'h01;
      case (st_reg)
        dma7_pkg::S_VEC: base_next[{idx_reg[1:0], 3'b000} +: 8] = i_mem_rdata;
        dma7_pkg::S_HDR,
        dma7_pkg::S_FLD: desc_next[idx_reg[4:0]] = i_mem_rdata;
        default:         acc_next[{idx_reg[0], 3'b000} +: 8] = i_mem_rdata;
      endcase
    end
    if (take) begin
      vec_next  = i_req_vector_addr;
      idx_next  = 6'h00;
      pair_next = 3'h0;
      st_next   = dma7_pkg::S_VEC;
    end
    if (step_done) begin
      idx_next = 6'h00;
      case (st_reg)
        dma7_pkg::S_VEC: st_next = dma7_pkg::S_HDR;
        dma7_pkg::S_HDR: begin
          if (cnt == 16'h0000) begin
            st_next = dma7_pkg::S_IDLE;
          end else begin
            idx_next = dma7_pkg::OFS_FLD;
            st_next  = dma7_pkg::S_FLD;
          end
        end
        dma7_pkg::S_FLD: begin
          dat_next = fit(src, mode[dma7_pkg::BIT_SIZE]);
          st_next  = first_st;
        end
        dma7_pkg::S_SRC: begin
          dat_next = fit(acc_reg, mode[dma7_pkg::BIT_SIZE]);
          st_next  = add ? dma7_pkg::S_OPR : dma7_pkg::S_DST;
        end
        dma7_pkg::S_OPR: begin
          dat_next = fit(dat_reg + acc_reg,
                         mode[dma7_pkg::BIT_SIZE]);
          st_next  = dma7_pkg::S_DST;
        end
        dma7_pkg::S_DST: begin
          desc_next[2] = c_dec[7:0];
          desc_next[3] = c_dec[15:8];
          if (!pairs_on) begin
            desc_next[o_src[4:0]]        = s_new[7:0];
            desc_next[o_src[4:0] + 5'h01] = s_new[15:8];
            desc_next[o_dst[4:0]]        = d_new[7:0];
            desc_next[o_dst[4:0] + 5'h01] = d_new[15:8];
            if (add) begin
              desc_next[o_opr[4:0]]        = o_new[7:0];
              desc_next[o_opr[4:0] + 5'h01] = o_new[15:8];
            end
          end
          if (more) begin
            pair_next = pairs_on ? pair_reg + 3'h1 : pair_reg;
            dat_next  = fit(s_new, mode[dma7_pkg::BIT_SIZE]);
            st_next   = first_st;
          end else begin
            idx_next = dma7_pkg::OFS_CNT;
            st_next  = dma7_pkg::S_WB;
          end
        end
        dma7_pkg::S_WB: begin
          st_next = dma7_pkg::S_IDLE;
          if (cnt == 16'h0000 && chain) begin
            st_next = dma7_pkg::S_CHAIN;
          end else if (cnt == 16'h0000 && done_irq_on) begin
            eot_next  = 1'b1;
            hand_next = {desc_reg[o_iad[4:0] + 5'h03],
                         desc_reg[o_iad[4:0] + 5'h02],
                         desc_reg[o_iad[4:0] + 5'h01],
                         desc_reg[o_iad[4:0]]};
          end
        end
        dma7_pkg::S_CHAIN: begin
          st_next   = dma7_pkg::S_IDLE;
          eot_next  = done_irq_on;
          hand_next = done_irq_on ? {desc_reg[o_iad[4:0] + 5'h03],
                              desc_reg[o_iad[4:0] + 5'h02],
                              desc_reg[o_iad[4:0] + 5'h01],
                              desc_reg[o_iad[4:0]]} : hand_reg;
        end
        default: st_next = dma7_pkg::S_IDLE;
      endcase
    end
  end

  // Engine state registers
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg <= dma7_pkg::S_IDLE;
      for (int i = 0; i < dma7_pkg::DESC_MAX; i++) begin
        desc_reg[i] <= 8'h00;
      end
      idx_reg  <= 6'h00;
      pend_reg <= 1'b0;
      vec_reg  <= dma7_pkg::ADDR_RESET;
      base_reg <= dma7_pkg::ADDR_RESET;
      acc_reg  <= 16'h0000;
      dat_reg  <= 16'h0000;
      pair_reg <= 3'h0;
      eot_reg  <= 1'b0;
      hand_reg <= dma7_pkg::ADDR_RESET;
    end else begin
      st_reg   <= st_next;
      desc_reg <= desc_next;
      idx_reg  <= idx_next;
      pend_reg <= pend_next;
      vec_reg  <= vec_next;
      base_reg <= base_next;
      acc_reg  <= acc_next;
      dat_reg  <= dat_next;
      pair_reg <= pair_next;
      eot_reg  <= eot_next;
      hand_reg <= hand_next;
    end
  end

  // Commands wait here so a stalled bus loses nothing
  two_entry_buffer #(
    .W     ($bits(dma7_pkg::mem_cmd_t)),
    .DEPTH (BUF_DEPTH)
  ) u_cmd_buf (
    .i_ref_clk (i_ref_clk),
    .i_arst_n  (i_arst_n),
    .i_valid   (issue),
    .o_ready   (buf_ready),
    .i_data    (cmd),
    .o_valid   (o_mem_valid),
    .i_ready   (i_mem_ready),
    .o_data    (o_mem_cmd)
  );

  // Checks on the engine's own behaviour
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  logic item_done;
  assign item_done = (st_reg == dma7_pkg::S_DST) && step_done;

  property p_level_only;
    o_req_ack |-> i_req_level == dma7_pkg::LVL_TOP ##1 st_reg == dma7_pkg::S_VEC;
  endproperty
  a_level_only: assert property (p_level_only)
    else $error("request taken at wrong level");
  property p_select;
    o_req_ack |-> i_level7_engine_select && !i_fast_interrupt_select;
  endproperty
  a_select: assert property (p_select)
    else $error("request taken while engine not routed");
  property p_unit8;
    issue && st_reg == dma7_pkg::S_DST && !mode[0] |-> idx_reg == 6'h00;
  endproperty
  a_unit8: assert property (p_unit8)
    else $error("second byte written in 8-bit mode");
  property p_space;
    issue && st_reg == dma7_pkg::S_SRC |-> cmd.addr <= 32'h0001_0000;
  endproperty
  a_space: assert property (p_space)
    else $error("source address outside 64K range");
  property p_src_step;
    item_done && !pairs_on |=> src == $past(s_new);
  endproperty
  a_src_step: assert property (p_src_step)
    else $error("source address step wrong");
  property p_count;
    item_done |=> cnt == $past(cnt) - 16'h0001;
  endproperty
  a_count: assert property (p_count)
    else $error("counter not decremented by one");
  property p_zero_cnt;
    st_reg == dma7_pkg::S_DST |-> cnt != 16'h0000;
  endproperty
  a_zero_cnt: assert property (p_zero_cnt)
    else $error("item moved with zero counter");
  property p_eot;
    o_eot_irq |-> cnt == 16'h0000 && done_irq_on &&
                  st_reg == dma7_pkg::S_IDLE;
  endproperty
  a_eot: assert property (p_eot)
    else $error("completion interrupt without zero count");
  property p_chain;
    issue && st_reg == dma7_pkg::S_CHAIN |-> chain && cnt == 16'h0000;
  endproperty
  a_chain: assert property (p_chain)
    else $error("vector rewritten without chain end");
  property p_hold;
    st_reg == dma7_pkg::S_DST && burst_on |-> o_irq_hold;
  endproperty
  a_hold: assert property (p_hold)
    else $error("interrupts not held during burst");

  c_burst: cover property (item_done && burst_on ##1
                           st_reg == dma7_pkg::S_DST);
  c_chain: cover property (st_reg == dma7_pkg::S_CHAIN && step_done);
  c_pairs: cover property (item_done && pairs_on && pair_reg == 3'h1);
  c_eot:   cover property (o_eot_irq);
endmodule : level7_dma_engine

// ---- rtl/two_entry_buffer.sv ----
// Small valid/ready buffer holding memory commands
`timescale 1ns/1ps
module two_entry_buffer #(
  parameter int W     = 41,
  parameter int DEPTH = 2
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_arst_n,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  if (DEPTH < 2) begin : g_bad_depth
    $error("two_entry_buffer needs DEPTH of at least 2");
  end

  logic [W-1:0]  mem_reg [DEPTH];
  logic [W-1:0]  mem_next [DEPTH];
  logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [PW:0]   cnt_reg, cnt_next;
  logic          push, pop;

  // Honest full and empty from the fill count
  assign o_ready = (cnt_reg != (PW+1)'(DEPTH));
  assign o_valid = (cnt_reg != '0);
  assign o_data  = mem_reg[rd_reg];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  // Pointer wrap and fill count
  always_comb begin
    mem_next = mem_reg;
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wr_reg] = i_data;
      wr_next = (wr_reg == PW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == PW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  // Storage and pointers
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule : two_entry_buffer

// ---- testbench/level7_dma_engine_bench.sv ----
// Self-checking bench for the level-7 transfer engine
`timescale 1ns/1ps
module level7_dma_engine_bench;
  logic               i_ref_clk;
  logic               i_arst_n;
  logic               i_req_valid;
  logic [2:0]         i_req_level;
  logic [31:0]        i_req_vector_addr;
  logic               i_level7_engine_select;
  logic               i_fast_interrupt_select;
  logic               o_req_ack;
  logic               o_mem_valid;
  logic               i_mem_ready;
  dma7_pkg::mem_cmd_t o_mem_cmd;
  logic               i_mem_rvalid;
  logic [7:0]         i_mem_rdata;
  logic               o_irq_hold;
  logic               o_eot_irq;
  logic [31:0]        o_eot_handler_addr;
  logic               o_busy;
  logic               slow;
  logic               hold_seen;
  logic [31:0]        hdl_seen;
  int                 eot_cnt;
  int                 error_cnt;
  int                 n_tests;

  level7_dma_engine DUT (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_req_valid(i_req_valid),
    .i_req_level(i_req_level), .i_req_vector_addr(i_req_vector_addr),
    .i_level7_engine_select(i_level7_engine_select),
    .i_fast_interrupt_select(i_fast_interrupt_select),
    .o_req_ack(o_req_ack), .o_mem_valid(o_mem_valid),
    .i_mem_ready(i_mem_ready), .o_mem_cmd(o_mem_cmd),
    .i_mem_rvalid(i_mem_rvalid), .i_mem_rdata(i_mem_rdata),
    .o_irq_hold(o_irq_hold), .o_eot_irq(o_eot_irq),
    .o_eot_handler_addr(o_eot_handler_addr), .o_busy(o_busy)
  );

  mem_partner u_mem (
    .i_ref_clk(i_ref_clk), .i_slow(slow), .i_valid(o_mem_valid),
    .o_ready(i_mem_ready), .i_cmd(o_mem_cmd), .o_rvalid(i_mem_rvalid),
    .o_rdata(i_mem_rdata)
  );

  // Clock at 200 MHz
  initial i_ref_clk = 1'b0;
  always #2.5 i_ref_clk = ~i_ref_clk;

  // Watch completion pulses and interrupt hold away from the edge
  always @(negedge i_ref_clk) begin
    if (o_eot_irq === 1'b1) begin
      eot_cnt++;
      hdl_seen = o_eot_handler_addr;
    end
    if (o_irq_hold === 1'b1) begin
      hold_seen = 1'b1;
    end
  end

  task automatic give_verdict;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Little-endian words into the memory model
  task automatic put(input logic [16:0] a, input logic [15:0] w[$]);
    foreach (w[i]) begin
      u_mem.mem[a + 17'(2 * i)] = w[i][7:0];
      u_mem.mem[a + 17'(2 * i + 1)] = w[i][15:8];
    end
  endtask : put

  function automatic logic [15:0] rd16(input logic [16:0] a);
    return {u_mem.mem[a + 17'h1], u_mem.mem[a]};
  endfunction : rd16

  // Hold a request until taken or refused, then wait for idle
  task automatic run_req(input logic [2:0] lvl, input logic sel,
                         input logic fast, input logic [31:0] vec,
                         input logic exp_ack);
    logic acked;
    acked = 1'b0;
    hold_seen = 1'b0;
    eot_cnt = 0;
    i_req_valid = 1'b1;
    i_req_level = lvl;
    i_req_vector_addr = vec;
    i_level7_engine_select = sel;
    i_fast_interrupt_select = fast;
    for (int k = 0; k < 20 && !acked; k++) begin
      #3;
      acked = (o_req_ack === 1'b1);
      @(posedge i_ref_clk);
    end
    #1 i_req_valid = 1'b0;
    chk(32'(acked), 32'(exp_ack));
    for (int k = 0; k < 3000 && o_busy !== 1'b0; k++) begin
      @(posedge i_ref_clk);
      #1;
    end
    // Let queued writes drain through a stalling memory
    repeat (8) @(posedge i_ref_clk);
    #1;
    chk(32'(o_busy), 32'h0);
  endtask : run_req

  initial begin
    repeat (30000) @(posedge i_ref_clk);
    error_cnt++;
    give_verdict();
  end

  // Reset, then descriptors in memory and requests
  initial begin
    error_cnt = 0;
    n_tests = 0;
    eot_cnt = 0;
    slow = 1'b0;
    i_arst_n = 1'b0;
    i_req_valid = 1'b0;
    i_req_level = 3'h0;
    i_req_vector_addr = 32'h0;
    i_level7_engine_select = 1'b1;
    i_fast_interrupt_select = 1'b0;
    repeat (3) @(posedge i_ref_clk);
    #1 i_arst_n = 1'b1;
    put(17'h0040, '{16'h0400, 16'h0000, 16'h0700, 16'h0000, 16'h0a00,
                    16'h0000, 16'h0b00, 16'h0000, 16'h0c00, 16'h0000});
    put(17'h0400, '{16'h004e, 16'h0002, 16'h0500, 16'h0600, 16'h1234,
                    16'h0008});
    put(17'h0500, '{16'h2211});
    put(17'h0600, '{16'h0000});
    run_req(3'h6, 1'b1, 1'b0, 32'h40, 1'b0);
    run_req(3'h7, 1'b0, 1'b0, 32'h40, 1'b0);
    run_req(3'h7, 1'b1, 1'b1, 32'h40, 1'b0);
    chk(rd16(17'h0600), 32'h0000);
    run_req(3'h7, 1'b1, 1'b0, 32'h40, 1'b1);
    chk(rd16(17'h0600), 32'h0011);
    chk(rd16(17'h0402), 32'h0001);
    chk(eot_cnt, 0);
    chk(32'(hold_seen), 32'h0);
    run_req(3'h7, 1'b1, 1'b0, 32'h40, 1'b1);
    chk(rd16(17'h0600), 32'h2211);
    chk(rd16(17'h0404), 32'h0502);
    chk(eot_cnt, 1);
    chk(hdl_seen, 32'h0008_1234);
    run_req(3'h7, 1'b1, 1'b0, 32'h40, 1'b1);
    chk(rd16(17'h0602), 32'hxxxx);
    chk(eot_cnt, 0);
    // Burst of 16-bit immediates with chain, memory stalling
    slow = 1'b1;
    put(17'h0700, '{16'h00a9, 16'h0003, 16'hbeef, 16'h0800, 16'h0900,
                    16'h0000});
    run_req(3'h7, 1'b1, 1'b0, 32'h44, 1'b1);
    chk(rd16(17'h0800), 32'hbeef);
    chk(rd16(17'h0804), 32'hbeef);
    chk(rd16(17'h0806), 32'hxxxx);
    chk(rd16(17'h0044), 32'h0900);
    chk(32'(hold_seen), 32'h1);
    chk(eot_cnt, 0);
    slow = 1'b0;
    // Sum at the top address, cut to 16 bits
    put(17'h0a00, '{16'h0013, 16'h0001, 16'hffff, 16'h0200, 16'h0300});
    put(17'h0ffff, '{16'h9000});
    put(17'h0200, '{16'h8123});
    run_req(3'h7, 1'b1, 1'b0, 32'h48, 1'b1);
    chk(rd16(17'h0300), 32'h1123);
    chk(32'(hold_seen), 32'h0);
    // 8-bit immediate uses the low byte only
    put(17'h0b00, '{16'h0000, 16'h0001, 16'h12ab, 16'h0310});
    put(17'h0310, '{16'h5555});
    run_req(3'h7, 1'b1, 1'b0, 32'h4c, 1'b1);
    chk(rd16(17'h0310), 32'h55ab);
    // Three address pairs in repeat mode
    put(17'h0c00, '{16'h8032, 16'h0005, 16'h0d00, 16'h0e00, 16'h0d01,
                    16'h0e01, 16'h0d02, 16'h0e02});
    put(17'h0d00, '{16'hb2a1, 16'h00c3});
    put(17'h0e00, '{16'h0000, 16'h0000});
    run_req(3'h7, 1'b1, 1'b0, 32'h50, 1'b1);
    chk(rd16(17'h0e00), 32'hb2a1);
    chk(rd16(17'h0e02), 32'h00c3);
    chk(rd16(17'h0c02), 32'h0002);
    chk(32'(hold_seen), 32'h1);
    give_verdict();
  end
endmodule : level7_dma_engine_bench

// ---- testbench/mem_partner.sv ----
// Byte-wide shared memory model that answers the engine's commands
`timescale 1ns/1ps
module mem_partner (
  input  wire logic               i_ref_clk,
  input  wire logic               i_slow,
  input  wire logic               i_valid,
  output logic                    o_ready,
  input  wire dma7_pkg::mem_cmd_t i_cmd,
  output logic                    o_rvalid,
  output logic [7:0]              o_rdata
);
  logic [7:0]  mem [0:131071];
  logic [16:0] rd_addr;
  logic [2:0]  tick_reg;
  logic [1:0]  wait_cnt;
  logic        pend;

  initial begin
    tick_reg = 3'h0;
    wait_cnt = 2'h0;
    pend = 1'b0;
    o_rvalid = 1'b0;
    o_rdata = 8'h5a;
  end

  // Slow mode refuses every other pair of cycles
  assign o_ready = !i_slow || tick_reg[1];

  // Store writes, answer each read after one or three cycles
  always @(posedge i_ref_clk) begin
    tick_reg <= tick_reg + 3'h1;
    o_rvalid <= 1'b0;
    o_rdata  <= ~o_rdata;
    if (pend && wait_cnt == 2'h0) begin
      o_rvalid <= 1'b1;
      o_rdata  <= mem[rd_addr];
      pend     <= 1'b0;
    end else if (pend) begin
      wait_cnt <= wait_cnt - 2'h1;
    end
    if (i_valid && o_ready) begin
      if (i_cmd.we) begin
        mem[i_cmd.addr[16:0]] <= i_cmd.data;
      end else begin
        pend     <= 1'b1;
        rd_addr  <= i_cmd.addr[16:0];
        wait_cnt <= i_slow ? 2'h2 : 2'h0;
      end
    end
  end
endmodule : mem_partner
